// *** design/chfs_regs.svh ***
// Purpose: Offsets, fields, resets and timing of the charger fault supervisor
// Assumes: Core clock of 10 MHz
// Notes:   Definitions only
`ifndef CHFS_REGS_SVH
`define CHFS_REGS_SVH
// Clock and protection timing, in ns; last one an overcurrent count limit
`define CHFS_CLK_NS         100
`define CHFS_OVP_DEB_NS     2000
`define CHFS_PRE_DEB_NS     10000
`define CHFS_WOC_TICK_NS    10000
`define CHFS_WOC_CLR_NS     50000000
`define CHFS_RETRY_LONG_NS  1300000000
`define CHFS_RETRY_SHORT_NS 150000000
`define CHFS_OT_COOL_NS     100000
`define CHFS_WOC_LIMIT      3'h7
// Converter sequencing
`define CHFS_NCHAN          5
`define CHFS_POLL_CYC       2000
`define CHFS_SAR_SETTLE     3'h7
// Register offsets
`define CHFS_OFS_CTRL       8'h00
`define CHFS_OFS_MAXSYS     8'h04
`define CHFS_OFS_STATUS     8'h08
`define CHFS_OFS_RESULT     8'h0C
// Control fields and reset
`define CHFS_CTRL_INT_EN    0
`define CHFS_CTRL_POL       2
`define CHFS_CTRL_CMP_EN    3
`define CHFS_CTRL_REF2V     4
`define CHFS_CTRL_WAY_OVERCURRENT_GUARD_DIS  9
`define CHFS_CTRL_RETRY_SH  11
`define CHFS_CTRL_BO_CMP_EN 12
`define CHFS_CTRL_MASK      16'h1A1D
`define CHFS_CTRL_RST       16'h1000
`define CHFS_MAXSYS_RST     8'h00
// Status fields
`define CHFS_ST_VDD         0
`define CHFS_ST_SW          1
`define CHFS_ST_ADP         2
`define CHFS_ST_OVP         3
`define CHFS_ST_PRE         4
`define CHFS_ST_SYSOV       5
`define CHFS_ST_WOCH        6
`define CHFS_ST_OT          7
`define CHFS_ST_CMP         8
`define CHFS_ST_WCNT        9
// Analog flag positions
`define CHFS_NFLAG          13
`define CHFS_F_VDD          0
`define CHFS_F_ADP          1
`define CHFS_F_ADP_OV       2
`define CHFS_F_ADP_REL      3
`define CHFS_F_SYS06        4
`define CHFS_F_SYS_OV       5
`define CHFS_F_SYS_REL      6
`define CHFS_F_WOC          7
`define CHFS_F_TJ_HOT       8
`define CHFS_F_TJ_COOL      9
`define CHFS_F_CMP_1V2      10
`define CHFS_F_CMP_2V       11
`define CHFS_F_ADC_CMP      12
`endif

// *** design/chfs_pkg.sv ***
// Purpose: Types of the charger fault supervisor
// Assumes: Nothing
// Notes:   Constants live in chfs_regs.svh
package chfs_pkg;
	typedef enum logic [1:0] {PRE_CHARGE, PRE_DEB, PRE_DONE} chfs_pre_e;
	typedef enum logic {WOC_RUN, WOC_HOLD} chfs_woc_e;
	typedef enum logic [1:0] {OT_OK, OT_HOT, OT_COOL, OT_WAIT} chfs_ot_e;
	typedef enum logic [1:0] {ADC_OFF, ADC_IDLE, ADC_CONV} chfs_adc_e;
	typedef logic [7:0] chfs_code_t;
endpackage

// *** design/chfs_supervisor.sv ***
// Purpose: Converter sequencing, protection machines and comparator pin
// Assumes: APB slave, one 10 MHz clock, analog flags asynchronous
// Notes:   Outputs registered, except comparator_output_o tied low
//
// The placing of the registers and the APB slave port were chosen for this implementation.
`timescale 1ns/100ps
`include "chfs_regs.svh"
module chfs_supervisor
	import chfs_pkg::*;
#(
	parameter int WOC_CLR_CYC     = `CHFS_WOC_CLR_NS / `CHFS_CLK_NS,
	parameter int RETRY_LONG_CYC  = (`CHFS_RETRY_LONG_NS + `CHFS_CLK_NS - 1) / `CHFS_CLK_NS,
	parameter int RETRY_SHORT_CYC = (`CHFS_RETRY_SHORT_NS + `CHFS_CLK_NS - 1) / `CHFS_CLK_NS,
	parameter int POLL_CYC        = `CHFS_POLL_CYC
)(
	input  wire logic                    clk_sys,
	input  wire logic                    rstn,
	input  wire logic                    psel,
	input  wire logic                    penable,
	input  wire logic                    pwrite,
	input  wire logic [7:0]              paddr,
	input  wire logic [31:0]             pwdata,
	output logic      [31:0]             prdata,
	output logic                         pready,
	output logic                         pslverr,
	input  wire logic [`CHFS_NFLAG-1:0]  sense_flags,
	input  wire logic                    int_req,
	output logic                         switch_en,
	output logic                         battery_fet_gate,
	output logic                         bypass_switch_gate,
	output logic                         precharge_en,
	output logic                         adapter_present_flag,
	output logic                         adc_en,
	output logic      [2:0]              adc_chan,
	output logic      [7:0]              adc_dac_code,
	output logic                         cmp_ref_2v,
	output logic                         comparator_output_o,
	output logic                         comparator_output_oe_n
);

	// Debounce lengths: least times round up
	localparam int OVP_CYC  = (`CHFS_OVP_DEB_NS + `CHFS_CLK_NS - 1) / `CHFS_CLK_NS;
	localparam int PRE_CYC  = (`CHFS_PRE_DEB_NS + `CHFS_CLK_NS - 1) / `CHFS_CLK_NS;
	localparam int TICK_CYC = (`CHFS_WOC_TICK_NS + `CHFS_CLK_NS - 1) / `CHFS_CLK_NS;
	localparam int COOL_CYC = (`CHFS_OT_COOL_NS + `CHFS_CLK_NS - 1) / `CHFS_CLK_NS;

	logic [`CHFS_NFLAG-1:0] sync1_ff;
	logic [`CHFS_NFLAG-1:0] sync2_ff;
	logic [`CHFS_NFLAG-1:0] nxt_sync1;
	logic [`CHFS_NFLAG-1:0] nxt_sync2;
	logic                   vdd_ok;
	logic                   adp_ok;
	logic                   adp_ov;
	logic                   adp_rel;
	logic                   sys06;
	logic                   sys_ov;
	logic                   sys_rel;
	logic                   woc_raw;
	logic                   tj_hot;
	logic                   tj_cool;
	logic                   adc_above;
	logic                   bat_only;

	// Two stages before any use; stage one feeds stage two only
	always_comb begin
		nxt_sync1 = sense_flags;
		nxt_sync2 = sync1_ff;
	end

	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			sync1_ff <= '0;
			sync2_ff <= '0;
		end else begin
			sync1_ff <= nxt_sync1;
			sync2_ff <= nxt_sync2;
		end
	end

	// Synchronised flag names
	assign vdd_ok    = sync2_ff[`CHFS_F_VDD];
	assign adp_ok    = sync2_ff[`CHFS_F_ADP];
	assign adp_ov    = sync2_ff[`CHFS_F_ADP_OV];
	assign adp_rel   = sync2_ff[`CHFS_F_ADP_REL];
	assign sys06     = sync2_ff[`CHFS_F_SYS06];
	assign sys_ov    = sync2_ff[`CHFS_F_SYS_OV];
	assign sys_rel   = sync2_ff[`CHFS_F_SYS_REL];
	assign woc_raw   = sync2_ff[`CHFS_F_WOC];
	assign tj_hot    = sync2_ff[`CHFS_F_TJ_HOT];
	assign tj_cool   = sync2_ff[`CHFS_F_TJ_COOL];
	assign adc_above = sync2_ff[`CHFS_F_ADC_CMP];
	assign bat_only  = ~adp_ok;

	logic [15:0]       ctrl_ff;
	logic [7:0]        maxsys_ff;
	logic [31:0]       prdata_ff;
	logic              pready_ff;
	logic              pslverr_ff;
	logic [15:0]       nxt_ctrl;
	logic [7:0]        nxt_maxsys;
	logic [31:0]       nxt_prdata;
	logic              nxt_pready;
	logic              nxt_pslverr;
	logic [15:0]       status;
	chfs_code_t        res_ff [`CHFS_NCHAN];
	logic              wr_en;
	logic              ready_st;
	logic [23:0]       retry_cyc;

	assign wr_en     = psel & penable & pready_ff & pwrite;
	assign ready_st  = (maxsys_ff == 8'h00);
	assign retry_cyc = ctrl_ff[`CHFS_CTRL_RETRY_SH] ? 24'(RETRY_SHORT_CYC) : 24'(RETRY_LONG_CYC);

	// APB slave: read data captured in setup, write data and pready in the first access cycle
	always_comb begin
		nxt_ctrl    = ctrl_ff;
		nxt_maxsys  = maxsys_ff;
		nxt_prdata  = prdata_ff;
		nxt_pready  = psel & ~penable;
		nxt_pslverr = 1'b0;
		if (psel && !penable) begin
			nxt_prdata  = 32'h0000_0000;
			nxt_pslverr = 1'b1;
			if (paddr == `CHFS_OFS_CTRL) begin
				nxt_prdata  = {16'h0000, ctrl_ff};
				nxt_pslverr = 1'b0;
			end
			if (paddr == `CHFS_OFS_MAXSYS) begin
				nxt_prdata  = {24'h000000, maxsys_ff};
				nxt_pslverr = 1'b0;
			end
			if (paddr == `CHFS_OFS_STATUS) begin
				nxt_prdata  = {16'h0000, status};
				nxt_pslverr = 1'b0;
			end
			for (int i = 0; i < `CHFS_NCHAN; i++) begin
				if (paddr == 8'(`CHFS_OFS_RESULT + 4 * i)) begin
					nxt_prdata  = {24'h000000, res_ff[i]};
					nxt_pslverr = 1'b0;
				end
			end
		end
		// Reserved control bits never stick, so they read zero
		if (wr_en && paddr == `CHFS_OFS_CTRL)
			nxt_ctrl = pwdata[15:0] & `CHFS_CTRL_MASK;
		if (wr_en && paddr == `CHFS_OFS_MAXSYS)
			nxt_maxsys = pwdata[7:0];
	end

	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			ctrl_ff    <= `CHFS_CTRL_RST;
			maxsys_ff  <= `CHFS_MAXSYS_RST;
			prdata_ff  <= 32'h0000_0000;
			pready_ff  <= 1'b0;
			pslverr_ff <= 1'b0;
		end else begin
			ctrl_ff    <= nxt_ctrl;
			maxsys_ff  <= nxt_maxsys;
			prdata_ff  <= nxt_prdata;
			pready_ff  <= nxt_pready;
			pslverr_ff <= nxt_pslverr;
		end
	end

	chfs_adc_e   adc_st_ff;
	chfs_adc_e   nxt_adc_st;
	logic [2:0]  chan_ff;
	logic [2:0]  nxt_chan;
	logic [2:0]  bit_ff;
	logic [2:0]  nxt_bit;
	logic [2:0]  step_ff;
	logic [2:0]  nxt_step;
	chfs_code_t  code_ff;
	chfs_code_t  nxt_code;
	logic [19:0] poll_ff;
	logic [19:0] nxt_poll;
	logic        adc_en_ff;
	logic        poll_tick;
	chfs_code_t  nxt_res [`CHFS_NCHAN];

	assign poll_tick = (poll_ff == 20'(POLL_CYC - 1));

	// SAR sequencer; settle time covers DAC plus synchroniser delay
	always_comb begin
		nxt_adc_st = adc_st_ff;
		nxt_chan   = chan_ff;
		nxt_bit    = bit_ff;
		nxt_step   = step_ff;
		nxt_code   = code_ff;
		nxt_poll   = poll_tick ? 20'h00000 : poll_ff + 20'h00001;
		for (int i = 0; i < `CHFS_NCHAN; i++)
			nxt_res[i] = res_ff[i];
		case (adc_st_ff)
			ADC_OFF: begin
				if (vdd_ok)
					nxt_adc_st = ADC_IDLE;
			end
			ADC_IDLE: begin
				if (poll_tick) begin
					nxt_adc_st = ADC_CONV;
					nxt_chan   = 3'h0;
					nxt_bit    = 3'h7;
					nxt_step   = 3'h0;
					nxt_code   = 8'h80;
				end
			end
			ADC_CONV: begin
				nxt_step = step_ff + 3'h1;
				if (step_ff == `CHFS_SAR_SETTLE) begin
					// 8-bit result cannot pass 255, so saturation is implicit
					if (!adc_above)
						nxt_code[bit_ff] = 1'b0;
					if (bit_ff != 3'h0) begin
						nxt_bit = bit_ff - 3'h1;
						nxt_code[bit_ff - 3'h1] = 1'b1;
					end else begin
						nxt_res[chan_ff] = nxt_code;
						nxt_bit          = 3'h7;
						nxt_code         = 8'h80;
						if (chan_ff == 3'(`CHFS_NCHAN - 1))
							nxt_adc_st = ADC_IDLE;
						else
							nxt_chan = chan_ff + 3'h1;
					end
				end
			end
			default: nxt_adc_st = ADC_OFF;
		endcase
		// Low supply aborts any conversion; old results stay readable
		if (!vdd_ok)
			nxt_adc_st = ADC_OFF;
	end

	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			adc_st_ff <= ADC_OFF;
			chan_ff   <= 3'h0;
			bit_ff    <= 3'h7;
			step_ff   <= 3'h0;
			code_ff   <= 8'h80;
			poll_ff   <= 20'h00000;
			adc_en_ff <= 1'b0;
			for (int i = 0; i < `CHFS_NCHAN; i++)
				res_ff[i] <= 8'h00;
		end else begin
			adc_st_ff <= nxt_adc_st;
			chan_ff   <= nxt_chan;
			bit_ff    <= nxt_bit;
			step_ff   <= nxt_step;
			code_ff   <= nxt_code;
			poll_ff   <= nxt_poll;
			adc_en_ff <= (nxt_adc_st != ADC_OFF);
			for (int i = 0; i < `CHFS_NCHAN; i++)
				res_ff[i] <= nxt_res[i];
		end
	end

	logic        ovp_ff;
	logic [7:0]  ovp_cnt_ff;
	chfs_pre_e   pre_ff;
	logic [7:0]  pre_cnt_ff;
	logic        sysov_ff;
	chfs_woc_e   woc_ff;
	logic [7:0]  tick_ff;
	logic [2:0]  wcnt_ff;
	logic [23:0] wclr_ff;
	logic [23:0] wdly_ff;
	chfs_ot_e    ot_ff;
	logic [23:0] ot_cnt_ff;
	logic        nxt_ovp;
	logic [7:0]  nxt_ovp_cnt;
	chfs_pre_e   nxt_pre;
	logic [7:0]  nxt_pre_cnt;
	logic        nxt_sysov;
	chfs_woc_e   nxt_woc;
	logic [7:0]  nxt_tick;
	logic [2:0]  nxt_wcnt;
	logic [23:0] nxt_wclr;
	logic [23:0] nxt_wdly;
	chfs_ot_e    nxt_ot;
	logic [23:0] nxt_ot_cnt;
	logic        woc_trip;
	logic        ready_q_ff;

	assign woc_trip = woc_raw & ~ctrl_ff[`CHFS_CTRL_WAY_OVERCURRENT_GUARD_DIS];

	// Protection machines
	always_comb begin
		nxt_ovp     = ovp_ff;
		nxt_ovp_cnt = 8'h00;
		nxt_pre     = pre_ff;
		nxt_pre_cnt = 8'h00;
		nxt_sysov   = sysov_ff;
		nxt_woc     = woc_ff;
		nxt_tick    = 8'h00;
		nxt_wcnt    = wcnt_ff;
		nxt_wclr    = (wclr_ff == 24'(WOC_CLR_CYC - 1)) ? 24'h000000 : wclr_ff + 24'h000001;
		nxt_wdly    = 24'h000000;
		nxt_ot      = ot_ff;
		nxt_ot_cnt  = 24'h000000;
		// Adapter overvoltage, debounced both ways
		if (!ovp_ff && adp_ov) begin
			nxt_ovp_cnt = ovp_cnt_ff + 8'h01;
			if (ovp_cnt_ff == 8'(OVP_CYC - 1))
				nxt_ovp = 1'b1;
		end
		if (ovp_ff && adp_rel) begin
			nxt_ovp_cnt = ovp_cnt_ff + 8'h01;
			if (ovp_cnt_ff == 8'(OVP_CYC - 1))
				nxt_ovp = 1'b0;
		end
		// Rail short qualification
		case (pre_ff)
			PRE_CHARGE: begin
				if (sys06)
					nxt_pre = PRE_DEB;
			end
			PRE_DEB: begin
				nxt_pre_cnt = pre_cnt_ff + 8'h01;
				if (!sys06)
					nxt_pre = PRE_CHARGE;
				else if (pre_cnt_ff == 8'(PRE_CYC - 1))
					nxt_pre = PRE_DONE;
			end
			PRE_DONE: nxt_pre = PRE_DONE;
			default: nxt_pre = PRE_CHARGE;
		endcase
		// Ready state parks the machine so leaving it requalifies
		if (ready_st)
			nxt_pre = PRE_CHARGE;
		// System overvoltage is a plain hysteresis latch
		if (sys_ov)
			nxt_sysov = 1'b1;
		else if (sys_rel)
			nxt_sysov = 1'b0;
		// Way overcurrent counting and retry
		if (wclr_ff == 24'(WOC_CLR_CYC - 1))
			nxt_wcnt = 3'h0;
		case (woc_ff)
			WOC_RUN: begin
				if (woc_trip) begin
					nxt_tick = tick_ff + 8'h01;
					if (tick_ff == 8'(TICK_CYC - 1)) begin
						nxt_tick = 8'h00;
						nxt_wcnt = wcnt_ff + 3'h1;
					end
				end
				if (wcnt_ff == `CHFS_WOC_LIMIT) begin
					nxt_woc  = WOC_HOLD;
					nxt_wcnt = 3'h0;
				end
			end
			WOC_HOLD: begin
				nxt_wdly = wdly_ff + 24'h000001;
				if (wdly_ff >= retry_cyc - 24'h000001) begin
					nxt_woc = WOC_RUN;
					nxt_pre = PRE_CHARGE;
				end
			end
			default: nxt_woc = WOC_RUN;
		endcase
		if (ctrl_ff[`CHFS_CTRL_WAY_OVERCURRENT_GUARD_DIS]) begin
			nxt_woc  = WOC_RUN;
			nxt_wcnt = 3'h0;
		end
		// Over-temperature with cool debounce then restart delay
		case (ot_ff)
			OT_OK: begin
				if (tj_hot)
					nxt_ot = OT_HOT;
			end
			OT_HOT: begin
				if (tj_cool && !tj_hot)
					nxt_ot = OT_COOL;
			end
			OT_COOL: begin
				nxt_ot_cnt = ot_cnt_ff + 24'h000001;
				if (!tj_cool || tj_hot)
					nxt_ot = OT_HOT;
				else if (ot_cnt_ff == 24'(COOL_CYC - 1)) begin
					nxt_ot     = OT_WAIT;
					nxt_ot_cnt = 24'h000000;
				end
			end
			OT_WAIT: begin
				nxt_ot_cnt = ot_cnt_ff + 24'h000001;
				if (tj_hot)
					nxt_ot = OT_HOT;
				else if (ot_cnt_ff >= retry_cyc - 24'h000001)
					nxt_ot = OT_OK;
			end
			default: nxt_ot = OT_OK;
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			ovp_ff     <= 1'b0;
			ovp_cnt_ff <= 8'h00;
			pre_ff     <= PRE_CHARGE;
			pre_cnt_ff <= 8'h00;
			sysov_ff   <= 1'b0;
			woc_ff     <= WOC_RUN;
			tick_ff    <= 8'h00;
			wcnt_ff    <= 3'h0;
			wclr_ff    <= 24'h000000;
			wdly_ff    <= 24'h000000;
			ot_ff      <= OT_OK;
			ot_cnt_ff  <= 24'h000000;
			ready_q_ff <= 1'b1;
		end else begin
			ovp_ff     <= nxt_ovp;
			ovp_cnt_ff <= nxt_ovp_cnt;
			pre_ff     <= nxt_pre;
			pre_cnt_ff <= nxt_pre_cnt;
			sysov_ff   <= nxt_sysov;
			woc_ff     <= nxt_woc;
			tick_ff    <= nxt_tick;
			wcnt_ff    <= nxt_wcnt;
			wclr_ff    <= nxt_wclr;
			wdly_ff    <= nxt_wdly;
			ot_ff      <= nxt_ot;
			ot_cnt_ff  <= nxt_ot_cnt;
			ready_q_ff <= ready_st;
		end
	end

	logic sw_ff;
	logic battery_fet_gate_ff;
	logic byp_ff;
	logic pre_en_ff;
	logic adp_flag_ff;
	logic ref2v_ff;
	logic pin_oe_n_ff;
	logic nxt_sw;
	logic nxt_adp_flag;
	logic cmp_on;
	logic cmp_above;
	logic cmp_level;
	logic ref2v;
	logic pull_low;

	// Comparator: battery-only forces 1.2V and uses its own enable
	assign ref2v     = ctrl_ff[`CHFS_CTRL_REF2V] & ~bat_only;
	assign cmp_on    = bat_only ? ctrl_ff[`CHFS_CTRL_BO_CMP_EN] : ctrl_ff[`CHFS_CTRL_CMP_EN];
	assign cmp_above = ref2v_ff ? sync2_ff[`CHFS_F_CMP_2V] : sync2_ff[`CHFS_F_CMP_1V2];
	assign cmp_level = cmp_above ^ ctrl_ff[`CHFS_CTRL_POL];
	assign pull_low  = (cmp_on & ~cmp_level) | (ctrl_ff[`CHFS_CTRL_INT_EN] & int_req);

	// Switching needs every guard clear and a nonzero system setting
	always_comb begin
		nxt_sw = ~ovp_ff & (pre_ff == PRE_DONE) & ~sysov_ff & (woc_ff == WOC_RUN) & ~woc_trip
			& (ot_ff == OT_OK) & ~ready_st & adp_ok;
		nxt_adp_flag = adp_ok & (woc_ff == WOC_RUN);
		if (ovp_ff)
			nxt_adp_flag = adp_flag_ff;
	end

	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			sw_ff       <= 1'b0;
			battery_fet_gate_ff    <= 1'b0;
			byp_ff      <= 1'b0;
			pre_en_ff   <= 1'b0;
			adp_flag_ff <= 1'b0;
			ref2v_ff    <= 1'b0;
			pin_oe_n_ff <= 1'b1;
		end else begin
			sw_ff       <= nxt_sw;
			battery_fet_gate_ff    <= ovp_ff | bat_only;
			byp_ff      <= ~woc_trip & (woc_ff == WOC_RUN);
			pre_en_ff   <= (pre_ff != PRE_DONE);
			adp_flag_ff <= nxt_adp_flag;
			ref2v_ff    <= ref2v;
			pin_oe_n_ff <= ~pull_low;
		end
	end

	// Status word for software
	always_comb begin
		status                       = 16'h0000;
		status[`CHFS_ST_VDD]         = vdd_ok;
		status[`CHFS_ST_SW]          = sw_ff;
		status[`CHFS_ST_ADP]         = adp_flag_ff;
		status[`CHFS_ST_OVP]         = ovp_ff;
		status[`CHFS_ST_PRE]         = (pre_ff == PRE_DONE);
		status[`CHFS_ST_SYSOV]       = sysov_ff;
		status[`CHFS_ST_WOCH]        = (woc_ff == WOC_HOLD);
		status[`CHFS_ST_OT]          = (ot_ff != OT_OK);
		status[`CHFS_ST_CMP]         = cmp_level;
		status[`CHFS_ST_WCNT +: 3]   = wcnt_ff;
	end

	// Port drive, all from registers except pin data, which is tied low
	assign prdata                 = prdata_ff;
	assign pready                 = pready_ff;
	assign pslverr                = pslverr_ff;
	assign switch_en              = sw_ff;
	assign battery_fet_gate       = battery_fet_gate_ff;
	assign bypass_switch_gate     = byp_ff;
	assign precharge_en           = pre_en_ff;
	assign adapter_present_flag   = adp_flag_ff;
	assign adc_en                 = adc_en_ff;
	assign adc_chan               = chan_ff;
	assign adc_dac_code           = code_ff;
	assign cmp_ref_2v             = ref2v_ff;
	assign comparator_output_o    = 1'b0;
	assign comparator_output_oe_n = pin_oe_n_ff;

	// Checks
	a_adc_low_vdd: assert property (@(posedge clk_sys) disable iff (!rstn)
		!vdd_ok |=> !adc_en_ff) else $error("converter active at low supply");
	a_ovp_stop: assert property (@(posedge clk_sys) disable iff (!rstn)
		ovp_ff |=> !sw_ff ##0 battery_fet_gate_ff) else $error("switching during adapter overvoltage");
	a_ovp_flag_hold: assert property (@(posedge clk_sys) disable iff (!rstn)
		ovp_ff |=> adp_flag_ff == $past(adp_flag_ff)) else $error("adapter flag moved in overvoltage");
	a_pre_no_sw: assert property (@(posedge clk_sys) disable iff (!rstn)
		pre_en_ff |-> !sw_ff) else $error("switching while precharging");
	a_pre_drop: assert property (@(posedge clk_sys) disable iff (!rstn)
		(pre_ff == PRE_DEB && !sys06) |=> pre_ff == PRE_CHARGE) else $error("rail drop not requalified");
	a_ready_requal: assert property (@(posedge clk_sys) disable iff (!rstn)
		(ready_q_ff && !ready_st) |-> pre_ff == PRE_CHARGE) else $error("ready exit skipped precharge");
	a_sysov_stop: assert property (@(posedge clk_sys) disable iff (!rstn)
		sys_ov |=> sysov_ff ##1 !sw_ff) else $error("system overvoltage not stopping");
	a_woc_gate: assert property (@(posedge clk_sys) disable iff (!rstn)
		woc_trip |=> !byp_ff) else $error("bypass gate on during trip");
	a_woc_shut: assert property (@(posedge clk_sys) disable iff (!rstn)
		(woc_ff == WOC_HOLD && !ovp_ff) |=> !adp_flag_ff && !sw_ff) else $error("no shutdown after count");
	a_woc_dis: assert property (@(posedge clk_sys) disable iff (!rstn)
		ctrl_ff[`CHFS_CTRL_WAY_OVERCURRENT_GUARD_DIS] |=> woc_ff == WOC_RUN && wcnt_ff == 3'h0) else $error("disabled guard acted");
	a_ot_stop: assert property (@(posedge clk_sys) disable iff (!rstn)
		tj_hot |=> ot_ff != OT_OK ##1 !sw_ff) else $error("switching while hot");
	a_pin_int: assert property (@(posedge clk_sys) disable iff (!rstn)
		(ctrl_ff[`CHFS_CTRL_INT_EN] && int_req) |=> !pin_oe_n_ff) else $error("interrupt not pulling pin");

endmodule // chfs_supervisor

// *** bench/chfs_sense_model.sv ***
// Purpose: Analog sense comparators beside the supervisor
// Assumes: Flag levels commanded by the bench
// Notes:   Converter input compared with the trial code
`timescale 1ns/100ps
module chfs_sense_model
	import chfs_pkg::*;
(
	input  wire logic        clk_sys,
	input  wire logic [11:0] lvl,
	input  wire chfs_code_t  ain [5],
	input  wire logic [2:0]  adc_chan,
	input  wire logic [7:0]  adc_dac_code,
	output logic      [12:0] sense_flags
);
	// Half-code offset: equal counts as above, so the result is ain
	always_ff @(posedge clk_sys) begin
		sense_flags <= {ain[adc_chan] >= adc_dac_code, lvl};
	end
endmodule // chfs_sense_model

// *** bench/tb.sv ***
// Purpose: Self-checking bench of the charger fault supervisor
// Assumes: Shortened timing parameters
// Notes:   Register reads checked through a queue
`timescale 1ns/100ps
`include "chfs_regs.svh"
module tb
	import chfs_pkg::*;
;
	logic        clk_sys, rstn, psel, penable, pwrite, pready, pslverr, int_req, sw, adp, bfet, aden, ref2, oe_n;
	logic        byp, pre, cmo;
	logic [7:0]  paddr, dac;
	logic [2:0]  chan;
	logic [31:0] pwdata, prdata;
	logic [11:0] lvl;
	logic [12:0] flags;
	logic [18:0] tab [5];
	chfs_code_t  ain [5];
	logic [32:0] exp_q [$];
	int          errors, checks;
	// Bench clock, 100 ns
	initial begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end
	chfs_supervisor #(.WOC_CLR_CYC(20000), .RETRY_LONG_CYC(300), .RETRY_SHORT_CYC(100), .POLL_CYC(400)) i_dut (
		.clk_sys(clk_sys), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .sense_flags(flags),
		.int_req(int_req), .switch_en(sw), .battery_fet_gate(bfet), .bypass_switch_gate(byp),
		.precharge_en(pre), .adapter_present_flag(adp), .adc_en(aden), .adc_chan(chan), .adc_dac_code(dac),
		.cmp_ref_2v(ref2), .comparator_output_o(cmo), .comparator_output_oe_n(oe_n));
	chfs_sense_model i_sense (.clk_sys(clk_sys), .lvl(lvl), .ain(ain), .adc_chan(chan),
		.adc_dac_code(dac), .sense_flags(flags));
	task automatic end_sim();
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic chk(input string name, input logic [32:0] seen, input logic [32:0] want);
		checks++;
		if (seen !== want) begin
			errors++;
			$display("BAD %s expected %h seen %h", name, want, seen);
		end
	endtask
	// One APB transfer; request held until pready is sampled high
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [32:0] want);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		if (!wr)
			exp_q.push_back(want);
		@(posedge clk_sys);
		penable <= 1'b1;
		do begin
			@(posedge clk_sys);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) begin
			errors++;
			end_sim();
		end else begin
			psel <= 1'b0;
			penable <= 1'b0;
			@(posedge clk_sys);
		end
	endtask
	task automatic st(input logic [11:0] v, input int w);
		repeat (w) @(posedge clk_sys);
		apb(1'b0, `CHFS_OFS_STATUS, 32'h0, {21'h0, v});
	endtask
	// Oldest noted read result against what the slave returns
	always @(posedge clk_sys) begin
		if (pready === 1'b1 && psel && penable && !pwrite && exp_q.size() > 0)
			chk("read", {pslverr, prdata}, exp_q.pop_front());
	end
	initial begin
		void'($urandom(5360));
		{rstn, psel, penable, pwrite, int_req} = 5'h00;
		paddr = 8'h00;
		pwdata = 32'h0;
		lvl = 12'h000;
		errors = 0;
		checks = 0;
		for (int i = 0; i < 5; i++)
			ain[i] = 8'($urandom);
		tab = '{{16'h1008, 3'h1}, {16'h100C, 3'h0}, {16'h1018, 3'h2}, {16'h1001, 3'h4}, {16'h1001, 3'h1}};
		repeat (8) @(posedge clk_sys);
		rstn <= 1'b1;
		@(posedge clk_sys);
		apb(1'b0, `CHFS_OFS_CTRL, 32'h0, 33'h1000);
		apb(1'b0, 8'h40, 32'h0, 33'h1_0000_0000);
		// One polling period converts every channel
		lvl <= 12'h001;
		repeat (760) @(posedge clk_sys);
		for (int c = 0; c < 5; c++)
			apb(1'b0, `CHFS_OFS_RESULT + 8'(4 * c), 32'h0, {25'h0, ain[c]});
		// Low supply stops the converter, results kept
		lvl <= 12'h000;
		ain[0] <= ~ain[0];
		repeat (800) @(posedge clk_sys);
		chk("converter on", aden, 1'b0);
		apb(1'b0, `CHFS_OFS_RESULT, 32'h0, {25'h0, ~ain[0]});
		// Rail qualification, then leaving the ready state
		lvl <= 12'h243;
		apb(1'b1, `CHFS_OFS_MAXSYS, 32'h80, 33'h0);
		st(12'h005, 5);
		chk("precharge", pre, 1'b1);
		lvl <= 12'h253;
		st(12'h017, 110);
		chk("precharge", pre, 1'b0);
		apb(1'b1, `CHFS_OFS_MAXSYS, 32'h0, 33'h0);
		apb(1'b1, `CHFS_OFS_MAXSYS, 32'h80, 33'h0);
		st(12'h005, 0);
		// Full requalification first; overvoltage needs the debounce both ways
		lvl <= 12'h25B;
		st(12'h017, 110);
		lvl <= 12'h257;
		st(12'h017, 10);
		st(12'h01D, 20);
		chk("battery gate", bfet, 1'b1);
		lvl <= 12'h25B;
		st(12'h017, 30);
		// System overvoltage, release without debounce; switch flop lags one edge
		lvl <= 12'h23B;
		st(12'h035, 5);
		lvl <= 12'h25B;
		st(12'h017, 5);
		// Overcurrent ignored while disabled, then counted to shutdown
		apb(1'b1, `CHFS_OFS_CTRL, 32'h1200, 33'h0);
		lvl <= 12'h2DB;
		repeat (750) @(posedge clk_sys);
		chk("switch bypass", {sw, byp}, 2'b11);
		apb(1'b1, `CHFS_OFS_CTRL, 32'h1000, 33'h0);
		repeat (750) @(posedge clk_sys);
		chk("flag switch bypass", {adp, sw, byp}, 3'b000);
		// Comparator reference, polarity and shared pin
		lvl <= 12'h65B;
		for (int k = 0; k < 5; k++) begin
			apb(1'b1, `CHFS_OFS_CTRL, {16'h0, tab[k][18:3]}, 33'h0);
			int_req <= tab[k][2];
			repeat (5) @(posedge clk_sys);
			chk("ref pin", {ref2, oe_n}, tab[k][1:0]);
		end
		// Hot die stops switching at once; restart needs cool time plus retry delay
		lvl <= 12'h55B;
		st(12'h195, 400);
		lvl <= 12'h65B;
		st(12'h195, 1200);
		st(12'h117, 150);
		// Battery only: own enable bit, reference forced to the low level
		lvl <= 12'h659;
		apb(1'b1, `CHFS_OFS_CTRL, 32'h1014, 33'h0);
		repeat (5) @(posedge clk_sys);
		chk("ref pin data", {ref2, oe_n, cmo}, 3'b000);
		end_sim();
	end
endmodule // tb
